// ---- rtl/hbd_defs.svh ----
// Constants for the host bus and DMA handshake block
`ifndef HBD_DEFS_SVH
`define HBD_DEFS_SVH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define HBD_CLK_NS 20
// Time that the acknowledge is driven high before it floats
`define HBD_ACK_RELEASE_NS 40
`define HBD_ACK_RELEASE_CYC ((`HBD_ACK_RELEASE_NS) / (`HBD_CLK_NS))
// Length of the done pulse on transmit terminal count
`define HBD_DONE_PULSE_NS 100
`define HBD_DONE_PULSE_CYC ((`HBD_DONE_PULSE_NS) / (`HBD_CLK_NS))

// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define HBD_NCH 2
`define HBD_DW 8
`define HBD_CNT_W 3
`define HBD_PIN_RST 1'h1
`define HBD_DATA_RST 8'h00

`endif

// ---- rtl/hbd_host_bus_dma_handshake.sv ----
// Host bus acknowledge, DMA handshake, done line and sync/RTS pins
//
// Function
// - The done line is active low and open drain, either side pulls it, in DMA and non-DMA modes.
// - The block pulls done on the last DMA read of the receive queue and on transmit count end.
// - In sync mode the channel pin goes low one bit time after a sync character or flag is seen.
// - In request-to-send mode the channel pin follows the software control bit.
// - On a processor write the acknowledge goes low once the bus data has been captured.
// - On a read or interrupt acknowledge the acknowledge goes low only once data is driven.
// - Processor write data is captured no later than acknowledge assertion or select negation.
// - The acknowledge goes high when select or interrupt acknowledge ends, then floats shortly.
// - Single-address DMA write data is captured on transfer complete or grant negation.
// - In single-address DMA the acknowledge ends on complete or grant negation, then floats.
`timescale 1ns/100ps
`include "hbd_defs.svh"
module hbd_host_bus_dma_handshake (
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire logic CHIP_SELECT_N,
  input wire logic INTR_ACK_N,
  input wire logic READ,
  input wire logic RX_DMA_GRANT_N,
  input wire logic TX_DMA_GRANT_N,
  input wire logic DMA_XFER_COMPLETE_N,
  input wire logic TRANSFER_DONE_N_IN,
  input wire logic [`HBD_DW-1:0] DATA_IN,
  input wire logic DMA_SINGLE_ADDR,
  input wire logic [`HBD_DW-1:0] RD_DATA,
  input wire logic RD_VALID,
  input wire logic RX_LAST,
  input wire logic TX_TERM_COUNT,
  input wire logic [`HBD_NCH-1:0] PIN_IS_RTS,
  input wire logic [`HBD_NCH-1:0] RTS_ON,
  input wire logic [`HBD_NCH-1:0] SYNC_SEEN,
  input wire logic [`HBD_NCH-1:0] SYNC_HUNT,
  input wire logic [`HBD_NCH-1:0] BIT_TICK,
  output logic BUS_CYCLE_ACK_N_OUT,
  output logic BUS_CYCLE_ACK_N_OE,
  output logic [`HBD_DW-1:0] DATA_OUT,
  output logic DATA_OE,
  output logic [`HBD_DW-1:0] WR_DATA,
  output logic WR_STROBE,
  output logic RD_REQ,
  output logic IACK_CYCLE,
  output logic TX_LAST_STROBE,
  output logic TRANSFER_DONE_N_OUT,
  output logic TRANSFER_DONE_N_OE,
  output logic [`HBD_NCH-1:0] CHAN_PIN_N
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  hbd_pkg::hbd_state_s_t s_reg;
  hbd_pkg::hbd_state_s_t s_next;
  hbd_pkg::hbd_pins_t pins;

  localparam logic [`HBD_CNT_W-1:0] ACK_REL_CYC = `HBD_CNT_W'(`HBD_ACK_RELEASE_CYC);
  localparam logic [`HBD_CNT_W-1:0] DONE_CYC = `HBD_CNT_W'(`HBD_DONE_PULSE_CYC);
  localparam logic [`HBD_CNT_W-1:0] CNT_ZERO = `HBD_CNT_W'(0);
  localparam logic [`HBD_CNT_W-1:0] CNT_ONE = `HBD_CNT_W'(1);

  // Gather the asynchronous host pins
  always_comb begin
    pins.chip_select_n = CHIP_SELECT_N;
    pins.intr_ack_n = INTR_ACK_N;
    pins.read = READ;
    pins.rx_grant_n = RX_DMA_GRANT_N;
    pins.tx_grant_n = TX_DMA_GRANT_N;
    pins.dma_xfer_complete_n = DMA_XFER_COMPLETE_N;
    pins.transfer_done_n = TRANSFER_DONE_N_IN;
    pins.data = DATA_IN;
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_next = s_reg;
    // Two-stage synchroniser, only stage two is read below
    s_next.s1 = pins;
    s_next.s2 = s_reg.s1;
    s_next.wr_stb = 1'b0;
    s_next.rd_req = 1'b0;
    s_next.tx_last = 1'b0;

    case (s_reg.st)
      hbd_pkg::HBD_IDLE: begin
        s_next.ack_oe = 1'b0;
        s_next.ack_n = 1'b1;
        s_next.dout_oe = 1'b0;
        if (!s_reg.s2.chip_select_n && !s_reg.s2.read) begin
          // Capture and acknowledge on the same edge
          s_next.wdata = s_reg.s2.data;
          s_next.wr_stb = 1'b1;
          s_next.ack_n = 1'b0;
          s_next.ack_oe = 1'b1;
          s_next.kind = hbd_pkg::HBD_K_CPU;
          s_next.st = hbd_pkg::HBD_ACK;
        end else if (!s_reg.s2.chip_select_n || !s_reg.s2.intr_ack_n) begin
          s_next.rd_req = 1'b1;
          s_next.kind = s_reg.s2.chip_select_n ? hbd_pkg::HBD_K_IACK : hbd_pkg::HBD_K_CPU;
          s_next.st = hbd_pkg::HBD_RD_WAIT;
        end else if (DMA_SINGLE_ADDR && !s_reg.s2.tx_grant_n) begin
          // Transmit grant opens a queue load cycle
          s_next.wdata = s_reg.s2.data;
          s_next.ack_n = 1'b0;
          s_next.ack_oe = 1'b1;
          s_next.kind = hbd_pkg::HBD_K_DMA;
          s_next.st = hbd_pkg::HBD_DMA_WR;
        end else if (DMA_SINGLE_ADDR && !s_reg.s2.rx_grant_n) begin
          s_next.rd_req = 1'b1;
          s_next.kind = hbd_pkg::HBD_K_DMA;
          s_next.st = hbd_pkg::HBD_DMA_RD;
        end
      end
      hbd_pkg::HBD_RD_WAIT: begin
        if (s_reg.kind == hbd_pkg::HBD_K_IACK ? s_reg.s2.intr_ack_n
            : s_reg.s2.chip_select_n) begin
          s_next.st = hbd_pkg::HBD_IDLE; // Cycle abandoned before data
        end else if (RD_VALID) begin
          s_next.dout = RD_DATA;
          s_next.dout_oe = 1'b1;
          s_next.st = hbd_pkg::HBD_ACK; // Data drives one cycle before ack
        end
      end
      hbd_pkg::HBD_DMA_RD: begin
        if (s_reg.s2.rx_grant_n || !s_reg.s2.dma_xfer_complete_n) begin
          s_next.st = hbd_pkg::HBD_IDLE;
        end else if (RD_VALID) begin
          s_next.dout = RD_DATA;
          s_next.dout_oe = 1'b1;
          s_next.rx_last_hold = RX_LAST;
          s_next.st = hbd_pkg::HBD_ACK;
        end
      end
      hbd_pkg::HBD_DMA_WR: begin
        if (!s_reg.s2.dma_xfer_complete_n || s_reg.s2.tx_grant_n) begin
          // Strobe the word sampled before the end, the bus may already be gone
          s_next.wr_stb = 1'b1;
          s_next.tx_last = !s_reg.s2.transfer_done_n;
          s_next.ack_n = 1'b1;
          s_next.rel_cnt = ACK_REL_CYC;
          s_next.st = hbd_pkg::HBD_RELEASE;
        end else begin
          // Follow the bus while the grant holds
          s_next.wdata = s_reg.s2.data;
        end
      end
      hbd_pkg::HBD_ACK: begin
        s_next.ack_n = 1'b0;
        s_next.ack_oe = 1'b1;
        if ((s_reg.kind == hbd_pkg::HBD_K_CPU && s_reg.s2.chip_select_n) ||
            (s_reg.kind == hbd_pkg::HBD_K_IACK && s_reg.s2.intr_ack_n)) begin
          s_next.ack_n = 1'b1;
          s_next.rel_cnt = ACK_REL_CYC;
          s_next.st = hbd_pkg::HBD_RELEASE;
        end else if (s_reg.kind == hbd_pkg::HBD_K_DMA &&
                     (!s_reg.s2.dma_xfer_complete_n || s_reg.s2.rx_grant_n)) begin
          s_next.ack_n = 1'b1;
          s_next.rel_cnt = ACK_REL_CYC;
          s_next.st = hbd_pkg::HBD_RELEASE;
        end
      end
      hbd_pkg::HBD_RELEASE: begin
        // Drive high briefly, then float
        s_next.dout_oe = 1'b0;
        s_next.rx_last_hold = 1'b0;
        if (s_reg.rel_cnt <= CNT_ONE) begin
          s_next.ack_oe = 1'b0;
          // A cycle ended by transfer complete may still hold its grant, so wait it out
          if (s_reg.s2.chip_select_n && s_reg.s2.intr_ack_n &&
              s_reg.s2.tx_grant_n && s_reg.s2.rx_grant_n) begin
            s_next.st = hbd_pkg::HBD_IDLE;
          end
        end else begin
          s_next.rel_cnt = s_reg.rel_cnt - CNT_ONE;
        end
      end
      default: begin
        s_next.st = hbd_pkg::HBD_IDLE;
        s_next.ack_oe = 1'b0;
      end
    endcase

    // Done pulse on transmit terminal count
    if (TX_TERM_COUNT) begin
      s_next.done_cnt = DONE_CYC;
    end else if (s_reg.done_cnt != CNT_ZERO) begin
      s_next.done_cnt = s_reg.done_cnt - CNT_ONE;
    end
    // Open drain: only ever drive low
    s_next.done_oe = s_next.rx_last_hold || (s_next.done_cnt != CNT_ZERO);
    s_next.done_n = !s_next.done_oe;

    // Channel pins: sync detect or request-to-send
    for (int i = 0; i < `HBD_NCH; i++) begin
      if (PIN_IS_RTS[i]) begin
        s_next.sync_armed[i] = 1'b0;
        s_next.pin_n[i] = !RTS_ON[i];
      end else begin
        if (SYNC_SEEN[i]) begin
          s_next.sync_armed[i] = 1'b1;
        end else if (s_reg.sync_armed[i] && BIT_TICK[i]) begin
          s_next.sync_armed[i] = 1'b0;
          s_next.pin_n[i] = 1'b0;
        end
        if (SYNC_HUNT[i]) begin
          s_next.sync_armed[i] = 1'b0;
          s_next.pin_n[i] = 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      s_reg <= '0;
      s_reg.s1 <= '1;
      s_reg.s2 <= '1;
      s_reg.st <= hbd_pkg::HBD_IDLE;
      s_reg.ack_n <= `HBD_PIN_RST;
      s_reg.done_n <= `HBD_PIN_RST;
      s_reg.dout <= `HBD_DATA_RST;
      s_reg.wdata <= `HBD_DATA_RST;
      s_reg.pin_n <= '1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // Outputs, all straight from flip-flops
  // ----------------------------------------
  assign BUS_CYCLE_ACK_N_OUT = s_reg.ack_n;
  assign BUS_CYCLE_ACK_N_OE = s_reg.ack_oe;
  assign DATA_OUT = s_reg.dout;
  assign DATA_OE = s_reg.dout_oe;
  assign WR_DATA = s_reg.wdata;
  assign WR_STROBE = s_reg.wr_stb;
  assign RD_REQ = s_reg.rd_req;
  assign IACK_CYCLE = s_reg.kind[0]; // Only the acknowledge kind has bit 0 set
  assign TX_LAST_STROBE = s_reg.tx_last;
  assign TRANSFER_DONE_N_OUT = s_reg.done_n;
  assign TRANSFER_DONE_N_OE = s_reg.done_oe;
  assign CHAN_PIN_N = s_reg.pin_n;

endmodule : hbd_host_bus_dma_handshake

// ---- rtl/hbd_pkg.sv ----
// Types for the host bus and DMA handshake block
`include "hbd_defs.svh"
package hbd_pkg;

  // Bus cycle states, one-hot
  typedef enum logic [5:0] {
    HBD_IDLE = 6'b00_0001,
    HBD_RD_WAIT = 6'b00_0010,
    HBD_ACK = 6'b00_0100,
    HBD_DMA_WR = 6'b00_1000,
    HBD_DMA_RD = 6'b01_0000,
    HBD_RELEASE = 6'b10_0000
  } hbd_state_t;

  // Kind of cycle in progress
  typedef enum logic [1:0] {
    HBD_K_CPU = 2'h0,
    HBD_K_IACK = 2'h1,
    HBD_K_DMA = 2'h2
  } hbd_kind_t;

  // Host pins as sampled
  typedef struct packed {
    logic chip_select_n;
    logic intr_ack_n;
    logic read;
    logic rx_grant_n;
    logic tx_grant_n;
    logic dma_xfer_complete_n;
    logic transfer_done_n;
    logic [`HBD_DW-1:0] data;
  } hbd_pins_t;

  // Whole block state
  typedef struct packed {
    hbd_pins_t s1;
    hbd_pins_t s2;
    hbd_state_t st;
    hbd_kind_t kind;
    logic [`HBD_CNT_W-1:0] rel_cnt;
    logic ack_n;
    logic ack_oe;
    logic [`HBD_DW-1:0] dout;
    logic dout_oe;
    logic [`HBD_DW-1:0] wdata;
    logic wr_stb;
    logic rd_req;
    logic tx_last;
    logic rx_last_hold;
    logic [`HBD_CNT_W-1:0] done_cnt;
    logic done_n;
    logic done_oe;
    logic [`HBD_NCH-1:0] sync_armed;
    logic [`HBD_NCH-1:0] pin_n;
  } hbd_state_s_t;

endpackage : hbd_pkg

// ---- test/hbd_assertions.sv ----
// Checker for the host bus and DMA handshake block
`timescale 1ns/100ps
module hbd_assertions (
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire logic CHIP_SELECT_N,
  input wire logic INTR_ACK_N,
  input wire logic RX_DMA_GRANT_N,
  input wire logic TX_DMA_GRANT_N,
  input wire logic DMA_XFER_COMPLETE_N,
  input wire logic DMA_SINGLE_ADDR,
  input wire logic TX_TERM_COUNT,
  input wire logic BUS_CYCLE_ACK_N_OUT,
  input wire logic BUS_CYCLE_ACK_N_OE,
  input wire logic DATA_OE,
  input wire logic WR_STROBE,
  input wire logic TX_LAST_STROBE,
  input wire logic TRANSFER_DONE_N_OUT,
  input wire logic TRANSFER_DONE_N_OE
);
  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);
  data_first_a: assert property (
    $rose(DATA_OE) |=> !BUS_CYCLE_ACK_N_OUT && BUS_CYCLE_ACK_N_OE)
    else $error("ack did not follow read data");
  write_ack_a: assert property (
    $fell(BUS_CYCLE_ACK_N_OUT) && TX_DMA_GRANT_N |-> WR_STROBE || DATA_OE)
    else $error("ack without capture or data");
  ack_release_a: assert property (
    $rose(BUS_CYCLE_ACK_N_OUT) |-> BUS_CYCLE_ACK_N_OE
    ##1 (BUS_CYCLE_ACK_N_OE && !DATA_OE) ##1 !BUS_CYCLE_ACK_N_OE)
    else $error("ack release timing wrong");
  idle_float_a: assert property (
    (CHIP_SELECT_N && INTR_ACK_N && TX_DMA_GRANT_N && RX_DMA_GRANT_N)[*8]
    |-> !BUS_CYCLE_ACK_N_OE && !DATA_OE)
    else $error("ack driven while idle");
  xfer_end_a: assert property (
    $fell(DMA_XFER_COMPLETE_N) && !BUS_CYCLE_ACK_N_OUT && DMA_SINGLE_ADDR && !TX_DMA_GRANT_N
    |-> ##[1:4] WR_STROBE && BUS_CYCLE_ACK_N_OUT)
    else $error("transfer complete not honoured");
  last_pair_a: assert property (TX_LAST_STROBE |-> WR_STROBE)
    else $error("last flag without write");
  done_low_a: assert property (TRANSFER_DONE_N_OE |-> !TRANSFER_DONE_N_OUT)
    else $error("done driven high");
  term_pulse_a: assert property (
    $rose(TX_TERM_COUNT) |=> (TRANSFER_DONE_N_OE && !TRANSFER_DONE_N_OUT)[*5])
    else $error("terminal count pulse short");
endmodule : hbd_assertions

bind hbd_host_bus_dma_handshake hbd_assertions i_chk (.*);

// ---- test/hbd_host_bus_dma_handshake_tb.sv ----
// Self-checking bench for the host bus and DMA handshake block
`timescale 1ns/100ps
`include "hbd_defs.svh"
module hbd_host_bus_dma_handshake_tb;
  logic CLK_SYS = 1'h0, RESETN = 1'h0, DMA_SINGLE_ADDR = 1'h0, RD_VALID = 1'h0;
  logic RX_LAST = 1'h0, TX_TERM_COUNT = 1'h0;
  logic [`HBD_DW-1:0] RD_DATA = 8'h00, DATA_IN, DATA_OUT, WR_DATA, wr_q, q;
  logic [`HBD_NCH-1:0] PIN_IS_RTS = 2'h2, RTS_ON = 2'h0, SYNC_SEEN = 2'h0;
  logic [`HBD_NCH-1:0] SYNC_HUNT = 2'h0, BIT_TICK = 2'h0, CHAN_PIN_N;
  logic CHIP_SELECT_N, INTR_ACK_N, READ, RX_DMA_GRANT_N, TX_DMA_GRANT_N, DMA_XFER_COMPLETE_N;
  logic TRANSFER_DONE_N_IN, BUS_CYCLE_ACK_N_OUT, BUS_CYCLE_ACK_N_OE, DATA_OE, WR_STROBE, RD_REQ;
  logic IACK_CYCLE, TX_LAST_STROBE, TRANSFER_DONE_N_OUT, TRANSFER_DONE_N_OE;
  logic last_q, ack_q, done_q, ok;
  int failures = 0, checks_done = 0;
  hbd_host_bus_dma_handshake i_dut (.*);
  hbd_host_model i_host (.*);
  // Clock
  always #(`HBD_CLK_NS / 2) CLK_SYS = ~CLK_SYS;
  // Core side answers a read request on the next falling edge
  always @(negedge CLK_SYS) if (RD_REQ === 1'h1) RD_VALID <= 1'h1;
  // Record each write strobe and done seen while read data drives
  always @(posedge CLK_SYS) begin
    if (WR_STROBE === 1'h1) begin
      {wr_q, last_q} <= {WR_DATA, TX_LAST_STROBE};
      ack_q <= BUS_CYCLE_ACK_N_OUT;
    end
    if (DATA_OE === 1'h1 && TRANSFER_DONE_N_IN === 1'h0) done_q <= 1'h1;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  // Processor write, read and interrupt acknowledge back to back
  task automatic t_host;
    logic [7:0] pat [3] = '{8'ha5, 8'h3c, 8'h47};
    for (int k = 0; k < 3; k++) begin
      RD_DATA = pat[k];
      i_host.cycle(3'(k), pat[k], 1'h0, q, ok);
      RD_VALID = 1'h0;
      chk(ok, 1'h1);
      if (k == 0) chk({wr_q, ack_q}, {pat[0], 1'h0});
      if (k > 0) chk(q, pat[k]);
      chk({IACK_CYCLE, BUS_CYCLE_ACK_N_OE, DATA_OE}, {k == 2, 2'h0});
    end
    $display("test host finished");
  endtask : t_host
  // Single-address DMA: refused, ended by complete, by grant, and last read
  task automatic t_dma;
    i_host.cycle(3'h3, 8'h11, 1'h0, q, ok);
    chk(ok, 1'h0);
    DMA_SINGLE_ADDR = 1'h1;
    i_host.cycle(3'h3, 8'h5a, 1'h1, q, ok);
    chk({wr_q, last_q, ack_q}, {8'h5a, 2'h3});
    i_host.cycle(3'h3, 8'hc3, 1'h0, q, ok);
    chk({wr_q, last_q, ack_q}, {8'hc3, 2'h1});
    {RD_DATA, RX_LAST, done_q} = {8'h96, 2'h2};
    i_host.cycle(3'h4, 8'h00, 1'h0, q, ok);
    {RD_VALID, RX_LAST} = 2'h0;
    chk({q, done_q, TRANSFER_DONE_N_IN}, {8'h96, 2'h3});
    $display("test dma finished");
  endtask : t_dma
  // Terminal count gives a done pulse of fixed length
  task automatic t_term;
    int n = 0;
    @(negedge CLK_SYS);
    TX_TERM_COUNT = 1'h1;
    @(negedge CLK_SYS);
    TX_TERM_COUNT = 1'h0;
    repeat (10) begin
      n += (TRANSFER_DONE_N_IN === 1'h0);
      @(negedge CLK_SYS);
    end
    chk(16'(n), 16'(`HBD_DONE_PULSE_CYC));
    $display("test terminal count finished");
  endtask : t_term
  // Channel 0 as sync detect, channel 1 as request-to-send
  task automatic t_pins;
    {RTS_ON, SYNC_SEEN} = 4'h9;
    @(negedge CLK_SYS);
    {SYNC_SEEN, BIT_TICK} = 4'h1;
    chk(CHAN_PIN_N, 2'h1);
    @(negedge CLK_SYS);
    {RTS_ON, BIT_TICK, SYNC_HUNT} = 6'h01;
    chk(CHAN_PIN_N, 2'h0);
    repeat (2) @(negedge CLK_SYS);
    chk(CHAN_PIN_N, 2'h3);
    $display("test pins finished");
  endtask : t_pins
  task automatic test_done;
    $display("checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done
  // Main sequence and watchdog
  initial begin
    repeat (10) @(negedge CLK_SYS);
    RESETN = 1'h1;
    repeat (3) @(negedge CLK_SYS);
    chk({BUS_CYCLE_ACK_N_OE, DATA_OE, TRANSFER_DONE_N_OE, CHAN_PIN_N}, 5'h03);
    t_host();
    t_dma();
    t_term();
    t_pins();
    test_done();
  end
  initial begin
    #200000;
    failures++;
    test_done();
  end
endmodule : hbd_host_bus_dma_handshake_tb

// ---- test/hbd_host_model.sv ----
// Host processor and DMA controller model facing the block
`timescale 1ns/100ps
`include "hbd_defs.svh"
module hbd_host_model (
  input wire logic CLK_SYS,
  input wire logic BUS_CYCLE_ACK_N_OUT,
  input wire logic BUS_CYCLE_ACK_N_OE,
  input wire logic [`HBD_DW-1:0] DATA_OUT,
  input wire logic DATA_OE,
  input wire logic TRANSFER_DONE_N_OUT,
  input wire logic TRANSFER_DONE_N_OE,
  output logic CHIP_SELECT_N,
  output logic INTR_ACK_N,
  output logic READ,
  output logic RX_DMA_GRANT_N,
  output logic TX_DMA_GRANT_N,
  output logic DMA_XFER_COMPLETE_N,
  output logic TRANSFER_DONE_N_IN,
  output logic [`HBD_DW-1:0] DATA_IN
);
  logic drv = 1'h0, pull = 1'h0, ack_w;
  logic [`HBD_DW-1:0] hd = 8'h00;
  // Pull-up on ack, open-drain done, a released bus shows the inverse
  assign ack_w = BUS_CYCLE_ACK_N_OE ? BUS_CYCLE_ACK_N_OUT : 1'h1;
  assign TRANSFER_DONE_N_IN = !(pull || (TRANSFER_DONE_N_OE && !TRANSFER_DONE_N_OUT));
  assign DATA_IN = drv ? hd : (DATA_OE ? DATA_OUT : ~hd);
  // All host and DMA strobes start inactive
  initial begin
    {CHIP_SELECT_N, INTR_ACK_N, READ} = 3'h7;
    {RX_DMA_GRANT_N, TX_DMA_GRANT_N, DMA_XFER_COMPLETE_N} = 3'h7;
  end
  // One cycle; k: 0 write, 1 read, 2 iack, 3 DMA write, 4 DMA read
  task automatic cycle(input logic [2:0] k, input logic [7:0] d, input logic last,
    output logic [7:0] q, output logic ok);
    int n;
    @(negedge CLK_SYS);
    hd = d;
    drv = (k == 3'h0 || k == 3'h3);
    READ = (k == 3'h1 || k == 3'h4);
    pull = last;
    case (k)
      3'h2: INTR_ACK_N = 1'h0;
      3'h3: TX_DMA_GRANT_N = 1'h0;
      3'h4: RX_DMA_GRANT_N = 1'h0;
      default: CHIP_SELECT_N = 1'h0;
    endcase
    for (n = 0; n < 20 && ack_w !== 1'h0; n++) @(posedge CLK_SYS);
    q = DATA_IN;
    ok = (n < 20);
    @(negedge CLK_SYS);
    if (last) begin
      DMA_XFER_COMPLETE_N = 1'h0;
      for (n = 0; n < 20 && ack_w !== 1'h1; n++) @(posedge CLK_SYS);
      @(negedge CLK_SYS);
    end
    {CHIP_SELECT_N, INTR_ACK_N, RX_DMA_GRANT_N, TX_DMA_GRANT_N, DMA_XFER_COMPLETE_N} = 5'h1f;
    {drv, pull} = 2'h0;
    for (n = 0; n < 20 && BUS_CYCLE_ACK_N_OE !== 1'h0; n++) @(posedge CLK_SYS);
    repeat (2) @(negedge CLK_SYS);
  endtask : cycle
endmodule : hbd_host_model
